// *** pkg/cds_pkg.sv ***
/*
  Constants, field layout, state codes and carrier types of the
  capacitive-divider scan sequencer for descriptors 1 and 2.
  Assumes a 32-bit APB register bus and one clock domain.
*/
package cds_pkg;
  // Byte offsets
  localparam logic [11:0] OFS_D1_C1  = 12'h110;
  localparam logic [11:0] OFS_D1_C2  = 12'h114;
  localparam logic [11:0] OFS_D1_C3  = 12'h118;
  localparam logic [11:0] OFS_D1_T2  = 12'h11c;
  localparam logic [11:0] OFS_D2_C1  = 12'h120;
  localparam logic [11:0] OFS_D2_C2  = 12'h124;
  localparam logic [11:0] OFS_D2_C3  = 12'h128;
  localparam logic [11:0] OFS_D2_T2  = 12'h12c;
  localparam logic [11:0] OFS_STATUS = 12'h140;
  // Reset value and writable masks
  localparam logic [31:0] RST_REG = 32'h00000000;
  localparam logic [31:0] MSK_C1  = 32'hffffff7f;
  localparam logic [31:0] MSK_C2  = 32'hffffffff;
  localparam logic [31:0] MSK_C3  = 32'hcf0f7f7f;
  localparam logic [31:0] MSK_T2  = 32'h7f7f7f7f;
  // Field positions
  localparam int EN_LO = 30;
  localparam int BUF_B = 27;
  localparam int IRQ_B = 26;
  localparam int SELF_B = 25;
  localparam int MUT_B = 24;
  localparam int DIV_B = 19;
  localparam int CAP_LO = 16;
  localparam int ACQ_LO = 8;
  localparam int CHG_LO = 0;
  localparam int CHN_LO = 24;
  localparam int OVT_LO = 16;
  localparam int POL_LO = 8;
  localparam int CON_LO = 0;
  localparam int THR_LO = 8;
  localparam int OVS_LO = 0;
  localparam int TXE_LO = 24;
  localparam int TXB_LO = 16;
  localparam int RXE_LO = 8;
  localparam int RXB_LO = 0;
  // Enable modes
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_ONCE = 2'h1;
  localparam logic [1:0] MODE_KEEP = 2'h2;
  localparam logic [1:0] MODE_LOOP = 2'h3;
  localparam int SMP_W = 12;
  localparam int ACC_W = 19;

  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_CHARGE = 8'h02, S_ACQUIRE = 8'h04, S_CONVERT = 8'h08,
    S_POLARITY = 8'h10, S_OVERSAMPLE_STATE = 8'h20, S_EVAL = 8'h40, S_CHANNEL = 8'h80
  } cds_state_t;

  typedef struct packed {
    logic [31:0] c1;
    logic [31:0] c2;
    logic [31:0] c3;
    logic [31:0] t2;
  } cds_desc_t;

  typedef struct packed {
    logic       active;
    logic       divider_on;
    logic       buf_route;
    logic [2:0] cap_sel;
    logic       charging;
    logic       polarity;
    logic       rx_en;
    logic [5:0] rx_first;
    logic [3:0] rx_step;
    logic       tx_en;
    logic [5:0] tx_first;
    logic [3:0] tx_step;
  } cds_elec_t;

  // Stride bits sit split across two byte lanes
  function automatic logic [3:0] rx_step_f(input logic [31:0] c2);
    rx_step_f = {c2[15], c2[14], c2[7], c2[6]};
  endfunction
  function automatic logic [3:0] tx_step_f(input logic [31:0] c2);
    tx_step_f = {c2[31], c2[30], c2[23], c2[22]};
  endfunction
  function automatic logic [1:0] mode_f(input logic [31:0] c3);
    mode_f = c3[EN_LO+:2];
  endfunction
  function automatic logic elig_f(input logic [31:0] c3);
    elig_f = (c3[EN_LO+:2] != MODE_OFF) && c3[DIV_B];
  endfunction
endpackage

// *** rtl/cds_timer.sv ***
/*
  Seven-bit state timer: loaded on state entry, counts down to one.
  Assumes load is a one-cycle strobe in the clock domain of pclk.
*/
`timescale 1ns/1ps
module cds_timer (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Control
  input  wire logic       load,
  input  wire logic [6:0] value,
  // Status
  output logic            expired
);
  logic [6:0] cnt_q;

  // Countdown; a value of zero lasts one cycle like a value of one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 7'h00;
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q > 7'h01) begin
      cnt_q <= cnt_q - 7'h01;
    end
  end

  assign expired = (cnt_q <= 7'h01);
endmodule // cds_timer

// *** rtl/cds_scan.sv ***
/*
  Scan sequencer for descriptors 1 and 2 with its APB register file.
  Assumes a synchronous converter that pulses adc_eoc with adc_data,
  and outside logic that stores measurements and routes the interrupt.
*/
`timescale 1ns/1ps
module cds_scan (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic [11:0]             paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic                         pready,
  output logic [31:0]                  prdata,
  output logic                         pslverr,
  // Shared converter
  output logic                         adc_start,
  input  wire logic                    adc_eoc,
  input  wire logic [11:0]             adc_data,
  // Electrode and divider control
  output cds_pkg::cds_elec_t           elec,
  // Measurement results
  output logic                         irq,
  output logic                         meas_valid,
  output logic                         meas_desc,
  output logic [19:0]                  meas_diff
);
  cds_pkg::cds_desc_t  dsc_q [2];
  cds_pkg::cds_state_t st_q;
  cds_pkg::cds_state_t st_d;
  logic                act_q;
  logic                act_d;
  logic                rpt_q;
  logic                pol_q;
  logic [6:0]          ovs_q;
  logic [5:0]          rx_q;
  logic [5:0]          tx_q;
  logic [18:0]         acc_a_q;
  logic [18:0]         acc_b_q;
  logic [11:0]         smp_q;
  logic                match_q;
  logic                adc_start_q;
  logic                irq_q;
  logic                mval_q;
  logic                mdesc_q;
  logic [19:0]         mdiff_q;
  logic [31:0]         prdata_q;
  logic                pslverr_q;
  logic [31:0]         c1;
  logic [31:0]         c2;
  logic [31:0]         c3;
  logic [31:0]         t2;
  logic                exp;
  logic                ld;
  logic [6:0]          tval;
  logic [19:0]         diff;
  logic                exceed;
  logic [6:0]          rx_nx;
  logic [6:0]          tx_nx;
  logic                tx_nx_end;
  logic                rx_wrap;
  logic                last_pair;
  logic                finish;
  logic                hw_clr;
  logic                busy;
  logic                wr;
  logic                hit;
  logic                hit_st;
  logic                sel_d;
  logic [1:0]          sel_w;

  assign c1 = dsc_q[act_q].c1;
  assign c2 = dsc_q[act_q].c2;
  assign c3 = dsc_q[act_q].c3;
  assign t2 = dsc_q[act_q].t2;
  assign busy = (st_q != cds_pkg::S_IDLE);

  // Address decode: descriptor, word, status
  always_comb begin
    hit    = 1'b1;
    hit_st = 1'b0;
    sel_d  = 1'b0;
    sel_w  = 2'h0;
    unique case (paddr)
      cds_pkg::OFS_D1_C1:  sel_w = 2'h0;
      cds_pkg::OFS_D1_C2:  sel_w = 2'h1;
      cds_pkg::OFS_D1_C3:  sel_w = 2'h2;
      cds_pkg::OFS_D1_T2:  sel_w = 2'h3;
      cds_pkg::OFS_D2_C1:  begin sel_d = 1'b1; sel_w = 2'h0; end
      cds_pkg::OFS_D2_C2:  begin sel_d = 1'b1; sel_w = 2'h1; end
      cds_pkg::OFS_D2_C3:  begin sel_d = 1'b1; sel_w = 2'h2; end
      cds_pkg::OFS_D2_T2:  begin sel_d = 1'b1; sel_w = 2'h3; end
      cds_pkg::OFS_STATUS: hit_st = 1'b1;
      default:             hit = 1'b0;
    endcase
  end

  // Zero-wait slave; write lands in the access phase
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite && hit && !hit_st;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // Read data and error captured in the setup phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h00000000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_q <= !hit || (pwrite && hit_st);
      if (!pwrite && hit_st) begin
        prdata_q <= {16'h0000, st_q, 3'h0, act_q, 2'h0, match_q, busy};
      end else if (!pwrite && hit) begin
        unique case (sel_w)
          2'h0: prdata_q <= dsc_q[sel_d].c1;
          2'h1: prdata_q <= dsc_q[sel_d].c2;
          2'h2: prdata_q <= dsc_q[sel_d].c3;
          2'h3: prdata_q <= dsc_q[sel_d].t2;
        endcase
      end else begin
        prdata_q <= 32'h00000000;
      end
    end
  end

  // Register file; a software write to the mode field beats the hardware clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 2; i++) begin
        dsc_q[i] <= {4{cds_pkg::RST_REG}};
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr && sel_d == i[0] && sel_w == 2'h0) begin
          dsc_q[i].c1 <= pwdata & cds_pkg::MSK_C1;
        end
        if (wr && sel_d == i[0] && sel_w == 2'h1) begin
          dsc_q[i].c2 <= pwdata & cds_pkg::MSK_C2;
        end
        if (wr && sel_d == i[0] && sel_w == 2'h2) begin
          dsc_q[i].c3 <= pwdata & cds_pkg::MSK_C3;
        end else if (hw_clr && act_q == i[0]) begin
          dsc_q[i].c3[cds_pkg::EN_LO+:2] <= cds_pkg::MODE_OFF;
        end
        if (wr && sel_d == i[0] && sel_w == 2'h3) begin
          dsc_q[i].t2 <= pwdata & cds_pkg::MSK_T2;
        end
      end
    end
  end

  // Pointer stepping and loop end
  assign rx_nx     = {1'b0, rx_q} + {3'h0, cds_pkg::rx_step_f(c2)} + 7'h01;
  assign tx_nx     = {1'b0, tx_q} + {3'h0, cds_pkg::tx_step_f(c2)} + 7'h01;
  assign rx_wrap   = rx_nx >= {1'b0, c2[cds_pkg::RXE_LO+:6]};
  assign tx_nx_end = tx_nx >= {1'b0, c2[cds_pkg::TXE_LO+:6]};
  assign last_pair = rx_wrap && tx_nx_end;
  assign finish    = (st_q == cds_pkg::S_CHANNEL) && exp && last_pair;
  assign hw_clr    = finish && ((cds_pkg::mode_f(c3) == cds_pkg::MODE_ONCE) ||
                     (cds_pkg::mode_f(c3) == cds_pkg::MODE_LOOP && match_q));

  // Difference of polarity accumulators against threshold
  assign diff   = {1'b0, acc_a_q} - {1'b0, acc_b_q};
  assign exceed = !diff[19] && ({5'h00, diff[18:0]} > c1[cds_pkg::THR_LO+:24]);

  // Next state and descriptor choice
  always_comb begin
    st_d  = st_q;
    act_d = act_q;
    unique case (st_q)
      cds_pkg::S_IDLE: begin
        if (rpt_q && cds_pkg::elig_f(c3)) begin
          st_d = cds_pkg::S_CHARGE;
        end else if (cds_pkg::elig_f(dsc_q[!act_q].c3)) begin
          act_d = !act_q;
          st_d  = cds_pkg::S_CHARGE;
        end else if (cds_pkg::elig_f(c3)) begin
          st_d = cds_pkg::S_CHARGE;
        end
      end
      cds_pkg::S_CHARGE:   if (exp) st_d = cds_pkg::S_ACQUIRE;
      cds_pkg::S_ACQUIRE:  if (exp) st_d = cds_pkg::S_CONVERT;
      cds_pkg::S_CONVERT: begin
        if (exp && !pol_q) begin
          st_d = cds_pkg::S_POLARITY;
        end else if (exp && ovs_q == c1[cds_pkg::OVS_LO+:7]) begin
          st_d = cds_pkg::S_EVAL;
        end else if (exp) begin
          st_d = cds_pkg::S_OVERSAMPLE_STATE;
        end
      end
      cds_pkg::S_POLARITY: if (exp) st_d = cds_pkg::S_CHARGE;
      cds_pkg::S_OVERSAMPLE_STATE: if (exp) st_d = cds_pkg::S_CHARGE;
      cds_pkg::S_EVAL:     st_d = cds_pkg::S_CHANNEL;
      cds_pkg::S_CHANNEL: begin
        if (finish) begin
          st_d = cds_pkg::S_IDLE;
        end else if (exp) begin
          st_d = cds_pkg::S_CHARGE;
        end
      end
    endcase
  end

  // Timer load value follows the state being entered
  always_comb begin
    ld   = (st_d != st_q);
    tval = 7'h00;
    unique case (st_d)
      cds_pkg::S_CHARGE:   tval = dsc_q[act_d].c3[cds_pkg::CHG_LO+:7];
      cds_pkg::S_ACQUIRE:  tval = c3[cds_pkg::ACQ_LO+:7];
      cds_pkg::S_CONVERT:  tval = t2[cds_pkg::CON_LO+:7];
      cds_pkg::S_POLARITY: tval = t2[cds_pkg::POL_LO+:7];
      cds_pkg::S_OVERSAMPLE_STATE: tval = t2[cds_pkg::OVT_LO+:7];
      cds_pkg::S_CHANNEL:  tval = t2[cds_pkg::CHN_LO+:7];
      default:             tval = 7'h00;
    endcase
  end

  cds_timer u_timer (
    .pclk    (pclk),
    .presetn (presetn),
    .load    (ld),
    .value   (tval),
    .expired (exp)
  );

  // State, active descriptor and repeat flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q  <= cds_pkg::S_IDLE;
      act_q <= 1'b1;
      rpt_q <= 1'b0;
    end else begin
      st_q  <= st_d;
      act_q <= act_d;
      if (finish) begin
        rpt_q <= (cds_pkg::mode_f(c3) == cds_pkg::MODE_LOOP) && !match_q;
      end else if (st_q == cds_pkg::S_IDLE) begin
        rpt_q <= 1'b0;
      end
    end
  end

  // Converter sample latch on end of conversion
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_q <= 12'h000;
    end else if (st_q == cds_pkg::S_CONVERT && adc_eoc) begin
      smp_q <= adc_data;
    end else if (ld && st_d == cds_pkg::S_CONVERT) begin
      smp_q <= 12'h000;
    end
  end

  // Accumulation, polarity and oversample count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_q   <= 1'b0;
      ovs_q   <= 7'h00;
      acc_a_q <= 19'h00000;
      acc_b_q <= 19'h00000;
    end else if ((st_q == cds_pkg::S_IDLE && ld) || (st_q == cds_pkg::S_CHANNEL && exp)) begin
      pol_q   <= 1'b0;
      ovs_q   <= 7'h00;
      acc_a_q <= 19'h00000;
      acc_b_q <= 19'h00000;
    end else if (st_q == cds_pkg::S_CONVERT && exp) begin
      pol_q <= !pol_q;
      if (!pol_q) begin
        acc_a_q <= acc_a_q + {7'h00, smp_q};
      end else begin
        acc_b_q <= acc_b_q + {7'h00, smp_q};
        ovs_q   <= ovs_q + 7'h01;
      end
    end
  end

  // Receive and transmit pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_q <= 6'h00;
      tx_q <= 6'h00;
    end else if (st_q == cds_pkg::S_IDLE && ld) begin
      rx_q <= dsc_q[act_d].c2[cds_pkg::RXB_LO+:6];
      tx_q <= dsc_q[act_d].c2[cds_pkg::TXB_LO+:6];
    end else if (st_q == cds_pkg::S_CHANNEL && exp && !last_pair) begin
      if (rx_wrap) begin
        rx_q <= c2[cds_pkg::RXB_LO+:6];
        tx_q <= tx_nx[5:0];
      end else begin
        rx_q <= rx_nx[5:0];
      end
    end
  end

  // Match flag of the current run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_q <= 1'b0;
    end else if (st_q == cds_pkg::S_IDLE && ld) begin
      match_q <= 1'b0;
    end else if (st_q == cds_pkg::S_EVAL && exceed) begin
      match_q <= 1'b1;
    end
  end

  // Result strobes, interrupt and converter start
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q       <= 1'b0;
      mval_q      <= 1'b0;
      mdesc_q     <= 1'b0;
      mdiff_q     <= 20'h00000;
      adc_start_q <= 1'b0;
    end else begin
      irq_q       <= (st_q == cds_pkg::S_EVAL) && exceed && c3[cds_pkg::IRQ_B];
      mval_q      <= (st_q == cds_pkg::S_EVAL) && exceed;
      adc_start_q <= ld && (st_d == cds_pkg::S_CONVERT);
      if (st_q == cds_pkg::S_EVAL) begin
        mdiff_q <= diff;
        mdesc_q <= act_q;
      end
    end
  end

  assign irq        = irq_q;
  assign meas_valid = mval_q;
  assign meas_desc  = mdesc_q;
  assign meas_diff  = mdiff_q;
  assign adc_start  = adc_start_q;

  // Electrode, divider and buffer steering from the active descriptor
  always_comb begin
    elec            = '0;
    elec.active     = busy;
    elec.divider_on = busy && c3[cds_pkg::DIV_B];
    elec.buf_route  = busy && c3[cds_pkg::BUF_B];
    elec.cap_sel    = busy ? c3[cds_pkg::CAP_LO+:3] : 3'h0;
    elec.charging   = (st_q == cds_pkg::S_CHARGE);
    elec.polarity   = pol_q;
    elec.rx_en      = busy && c3[cds_pkg::SELF_B];
    elec.rx_first   = rx_q;
    elec.rx_step    = cds_pkg::rx_step_f(c2);
    elec.tx_en      = busy && c3[cds_pkg::MUT_B];
    elec.tx_first   = tx_q;
    elec.tx_step    = cds_pkg::tx_step_f(c2);
  end

  // Checking helpers: state age and load value
  logic [6:0] age_q;
  logic [6:0] lval_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q  <= 7'h00;
      lval_q <= 7'h00;
    end else if (ld) begin
      age_q  <= 7'h00;
      lval_q <= tval;
    end else if (age_q != 7'h7f) begin
      age_q <= age_q + 7'h01;
    end
  end

  sequence s_done;
    finish && !wr;
  endsequence

  property p_once;
    @(posedge pclk) disable iff (!presetn)
      s_done ##0 (cds_pkg::mode_f(c3) == cds_pkg::MODE_ONCE) |=> (cds_pkg::mode_f(c3) == cds_pkg::MODE_OFF);
  endproperty
  a_once: assert property (p_once) else $error("once mode not cleared");

  property p_keep;
    @(posedge pclk) disable iff (!presetn)
      s_done ##0 (cds_pkg::mode_f(c3) == cds_pkg::MODE_KEEP) |=> (cds_pkg::mode_f(c3) == cds_pkg::MODE_KEEP);
  endproperty
  a_keep: assert property (p_keep) else $error("keep mode lost");

  property p_loop;
    @(posedge pclk) disable iff (!presetn)
      s_done ##0 (cds_pkg::mode_f(c3) == cds_pkg::MODE_LOOP) ##0 !match_q |=> rpt_q ##1 (st_q == cds_pkg::S_CHARGE);
  endproperty
  a_loop: assert property (p_loop) else $error("loop mode did not repeat");

  property p_off;
    @(posedge pclk) disable iff (!presetn)
      (st_q == cds_pkg::S_IDLE) && !cds_pkg::elig_f(dsc_q[0].c3) && !cds_pkg::elig_f(dsc_q[1].c3) |=> !busy;
  endproperty
  a_off: assert property (p_off) else $error("disabled descriptor ran");

  property p_irq;
    @(posedge pclk) disable iff (!presetn)
      irq |-> meas_valid && $past(c3[cds_pkg::IRQ_B]) && $past(st_q == cds_pkg::S_EVAL);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt without enabled exceed");

  property p_route;
    @(posedge pclk) disable iff (!presetn)
      (elec.buf_route == (busy && c3[cds_pkg::BUF_B])) && (!elec.rx_en || c3[cds_pkg::SELF_B]) &&
      (!elec.tx_en || c3[cds_pkg::MUT_B]) && (!elec.divider_on || busy);
  endproperty
  a_route: assert property (p_route) else $error("steering outputs disagree with mode bits");

  property p_len;
    @(posedge pclk) disable iff (!presetn)
      busy && (st_q != cds_pkg::S_EVAL) && exp |-> (age_q + 7'h01 == ((lval_q == 7'h00) ? 7'h01 : lval_q));
  endproperty
  a_len: assert property (p_len) else $error("state length differs from its timer field");

  property p_stay;
    @(posedge pclk) disable iff (!presetn)
      busy && (st_q != cds_pkg::S_EVAL) && !exp |=> $stable(st_q);
  endproperty
  a_stay: assert property (p_stay) else $error("state left before its timer expired");

  property p_rxstep;
    @(posedge pclk) disable iff (!presetn)
      (st_q == cds_pkg::S_CHANNEL) && exp && !rx_wrap |=> (rx_q == $past(rx_nx[5:0]));
  endproperty
  a_rxstep: assert property (p_rxstep) else $error("receive pointer stepped wrongly");

  property p_ovs;
    @(posedge pclk) disable iff (!presetn)
      (st_q == cds_pkg::S_EVAL) |-> (ovs_q == c1[cds_pkg::OVS_LO+:7] + 7'h01);
  endproperty
  a_ovs: assert property (p_ovs) else $error("oversample count wrong at evaluation");
endmodule // cds_scan

// *** tb/cds_adc_model.sv ***
/* Behavioural shared converter for the scan sequencer.
   Assumes one-cycle adc_start pulses and a convert time of at least six cycles. */
`timescale 1ns/1ps
module cds_adc_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Converter side
  input  wire logic        adc_start,
  output logic             adc_eoc,
  output logic [11:0]      adc_data,
  // Levels of the two polarities
  input  wire logic [11:0] lvl_a,
  input  wire logic [11:0] lvl_b
);
  logic [1:0] cnt_q;
  logic       odd_q;
  // End of conversion four cycles after start, data churns otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q    <= 2'h0;
      odd_q    <= 1'b0;
      adc_eoc  <= 1'b0;
      adc_data <= 12'h000;
    end else begin
      adc_eoc <= (cnt_q == 2'h1);
      if (adc_start) cnt_q <= 2'h3;
      else if (cnt_q != 2'h0) cnt_q <= cnt_q - 2'h1;
      if (cnt_q == 2'h1) begin
        adc_data <= odd_q ? lvl_b : lvl_a;
        odd_q    <= ~odd_q;
      end else adc_data <= ~adc_data;
    end
  end
endmodule // cds_adc_model

// *** tb/cds_scan_test.sv ***
/* Self-checking bench of the scan sequencer: registers, descriptor 2 in once, loop and keep modes.
   Assumes the converter model beside it and a zero-wait APB slave. */
`timescale 1ns/1ps
module cds_scan_test;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               adc_start, adc_eoc, irq, meas_valid, meas_desc;
  logic [11:0]        paddr, adc_data, lvl_a, lvl_b, a, b;
  logic [31:0]        pwdata, prdata, seed;
  logic [19:0]        meas_diff;
  logic [33:0]        note;
  logic               irq_exp;
  cds_pkg::cds_elec_t elec;
  int                 mismatches, checked, n;
  logic [33:0]        apb_q[$];
  logic [19:0]        meas_q[$];

  cds_scan DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .adc_start(adc_start), .adc_eoc(adc_eoc), .adc_data(adc_data), .elec(elec), .irq(irq),
    .meas_valid(meas_valid), .meas_desc(meas_desc), .meas_diff(meas_diff));
  cds_adc_model u_adc (.pclk(pclk), .presetn(presetn), .adc_start(adc_start), .adc_eoc(adc_eoc),
    .adc_data(adc_data), .lvl_a(lvl_a), .lvl_b(lvl_b));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // One APB transfer; note is {check data, error, data}
  task apb(input logic [11:0] ad, input logic w, input logic [31:0] d, input logic [33:0] nt);
    @(posedge pclk);
    {psel, penable, paddr, pwrite, pwdata} <= {2'b10, ad, w, d};
    apb_q.push_back(nt);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {psel, penable} <= 2'b00;
  endtask
  // Wait for a busy level; running out of cycles shows as a mismatch
  task wait_busy(input logic lvl, input int lim);
    n = 0;
    while (elec.active !== lvl && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check("busy", {31'h0, elec.active}, {31'h0, lvl});
  endtask

  // Answer monitor
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && apb_q.size() > 0) begin
      note = apb_q.pop_front();
      check("pslverr", {31'h0, pslverr}, {31'h0, note[32]});
      if (note[33]) check("prdata", prdata, note[31:0]);
    end
    if (meas_valid === 1'b1) begin
      check("meas_diff", {12'h0, meas_diff}, {12'h0, meas_q.size() > 0 ? meas_q.pop_front() : 20'hfffff});
      check("irq", {31'h0, irq}, {31'h0, irq_exp});
      check("meas_desc", {31'h0, meas_desc}, 32'h1);
    end
  end

  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, lvl_a, lvl_b} = '0;
    irq_exp = 1'b1;
    presetn = 1'b0;
    seed = 32'he8dc4cbb;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++) apb(cds_pkg::OFS_D1_T2 + 12'(4 * i), 1'b0, 32'h0, {2'b10, 32'h0});
    apb(cds_pkg::OFS_D1_T2, 1'b1, 32'hffffffff, {2'b00, 32'h0});
    apb(cds_pkg::OFS_D1_T2, 1'b0, 32'h0, {2'b10, 32'h7f7f7f7f});
    apb(cds_pkg::OFS_D2_C3, 1'b1, 32'h3fffffff, {2'b00, 32'h0});
    apb(cds_pkg::OFS_D2_C3, 1'b0, 32'h0, {2'b10, 32'h0f0f7f7f});
    apb(cds_pkg::OFS_STATUS, 1'b0, 32'h0, {2'b10, 32'h00000110});
    apb(12'h150, 1'b0, 32'h0, {2'b01, 32'h0});
    apb(cds_pkg::OFS_STATUS, 1'b1, 32'h0, {2'b01, 32'h0});
    seed = lfsr(seed);
    a = 12'h800 | seed[10:0];
    seed = lfsr(seed);
    b = {2'b00, seed[9:0]};
    lvl_a <= a;
    lvl_b <= b;
    repeat (2) meas_q.push_back(20'(2 * ({8'h0, a} - {8'h0, b})));
    apb(cds_pkg::OFS_D2_C1, 1'b1, 32'h00000101, {2'b00, 32'h0});
    apb(cds_pkg::OFS_D2_C2, 1'b1, 32'h01000200, {2'b00, 32'h0});
    apb(cds_pkg::OFS_D2_T2, 1'b1, 32'h02010108, {2'b00, 32'h0});
    apb(cds_pkg::OFS_D2_C3, 1'b1, 32'h4f0d0203, {2'b00, 32'h0});
    wait_busy(1'b1, 100);
    check("elec", {25'h0, elec.divider_on, elec.buf_route, elec.cap_sel, elec.rx_en, elec.tx_en}, 32'h77);
    wait_busy(1'b0, 5000);
    check("meas left", meas_q.size(), 32'h0);
    apb(cds_pkg::OFS_D2_C3, 1'b0, 32'h0, {2'b10, 32'h0f0d0203});
    // Loop mode, interrupt off: the first run matches, so the mode clears
    irq_exp = 1'b0;
    repeat (2) meas_q.push_back(20'(2 * ({8'h0, a} - {8'h0, b})));
    apb(cds_pkg::OFS_D2_C3, 1'b1, 32'hcb0d0203, {2'b00, 32'h0});
    wait_busy(1'b1, 100);
    wait_busy(1'b0, 5000);
    check("meas left", meas_q.size(), 32'h0);
    apb(cds_pkg::OFS_D2_C3, 1'b0, 32'h0, {2'b10, 32'h0b0d0203});
    // Keep mode, unreachable threshold: starts again until switched off
    apb(cds_pkg::OFS_D2_C1, 1'b1, 32'hffffff01, {2'b00, 32'h0});
    apb(cds_pkg::OFS_D2_C3, 1'b1, 32'h8f0d0203, {2'b00, 32'h0});
    wait_busy(1'b1, 100);
    wait_busy(1'b0, 5000);
    wait_busy(1'b1, 4);
    apb(cds_pkg::OFS_D2_C3, 1'b0, 32'h0, {2'b10, 32'h8f0d0203});
    apb(cds_pkg::OFS_D2_C3, 1'b1, 32'h0, {2'b00, 32'h0});
    wait_busy(1'b0, 5000);
    repeat (2) @(posedge pclk);
    wrap_up;
  end
endmodule // cds_scan_test
